// File: core/tsp_gen.sv
`include "tsp_params.svh"
`default_nettype none

module tsp_gen (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Encoder request
    input wire logic sym_start,
    input wire logic [1:0] sym_sel,
    input wire logic [7:0] low_pair_burst_length,
    // Encoder output
    output logic tx_bit,
    output logic tx_valid,
    output logic tx_busy,
    output logic [2:0] active_bitrate_sel,
    output logic active_subcarrier_sel,
    output logic active_bitrate_reserved
);

    tsp_pkg::tsp_regs_s q;
    tsp_pkg::tsp_regs_s d;

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Word index, or all ones for an unmapped or misaligned address
    function automatic logic [7:0] reg_index(input logic [11:0] a);
        logic [7:0] idx;
        idx = a[9:2];
        if (a[1:0] != 2'h0 || a[11:10] != 2'h0) begin
            reg_index = 8'hFF;
        end else if ((idx >= `TSP_IDX_FREQ && idx <= `TSP_IDX_MOD10)
                     || idx == `TSP_IDX_STATUS) begin
            reg_index = idx;
        end else begin
            reg_index = 8'hFF;
        end
    endfunction : reg_index

    function automatic logic [15:0] slot_pattern(input logic [1:0] s);
        case (s)
            2'h0: slot_pattern = {q.p0_hi, q.p0_lo};
            2'h1: slot_pattern = {q.p1_hi, q.p1_lo};
            2'h2: slot_pattern = {8'h00, q.p2};
            default: slot_pattern = {8'h00, q.p3};
        endcase
    endfunction : slot_pattern

    // Field value: the count of valid bits less one
    function automatic logic [3:0] slot_length(input logic [1:0] s);
        case (s)
            2'h0: slot_length = q.len10[`TSP_LEN0_MSB:`TSP_LEN0_LSB];
            2'h1: slot_length = q.len10[`TSP_LEN1_MSB:`TSP_LEN1_LSB];
            2'h2: slot_length = {1'b0, q.len32[`TSP_LEN2_MSB:`TSP_LEN2_LSB]};
            default: slot_length = {1'b0, q.len32[`TSP_LEN3_MSB:`TSP_LEN3_LSB]};
        endcase
    endfunction : slot_length

    function automatic logic burst_en(input logic [1:0] s);
        burst_en = (s == 2'h0) ? q.burst[`TSP_B0_EN]
                 : (s == 2'h1) ? q.burst[`TSP_B1_EN] : 1'b0;
    endfunction : burst_en

    function automatic logic burst_alone(input logic [1:0] s);
        burst_alone = (s == 2'h0) ? q.burst[`TSP_B0_ALONE]
                    : (s == 2'h1) ? q.burst[`TSP_B1_ALONE] : 1'b0;
    endfunction : burst_alone

    function automatic logic burst_level(input logic [1:0] s);
        burst_level = (s == 2'h0) ? q.burst[`TSP_B0_LEVEL]
                                  : q.burst[`TSP_B1_LEVEL];
    endfunction : burst_level

    // High pair inversion lives outside this block
    function automatic logic slot_invert(input logic [1:0] s);
        slot_invert = ~s[1] & q.mod10[`TSP_INV_BIT];
    endfunction : slot_invert

    ////////////////////////////////////////////////////////////////////////
    // Next state

    logic [7:0] sel;
    logic access;
    logic wr_en;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic [15:0] pat_word;

    always_comb begin
        d = q;
        sel = reg_index(paddr);
        // One wait state: data is ready one cycle into the access phase
        access = psel & penable & ~q.pready;
        wr_en = psel & penable & q.pready & pwrite & pstrb[0]
              & (sel != 8'hFF);
        wbyte = pwdata[7:0];
        rbyte = 8'h00;
        case (sel)
            `TSP_IDX_FREQ: rbyte = q.freq;
            `TSP_IDX_P0_HI: rbyte = q.p0_hi;
            `TSP_IDX_P0_LO: rbyte = q.p0_lo;
            `TSP_IDX_P1_HI: rbyte = q.p1_hi;
            `TSP_IDX_P1_LO: rbyte = q.p1_lo;
            `TSP_IDX_P2: rbyte = q.p2;
            `TSP_IDX_P3: rbyte = q.p3;
            `TSP_IDX_LEN10: rbyte = q.len10;
            `TSP_IDX_LEN32: rbyte = q.len32;
            `TSP_IDX_BURST: rbyte = q.burst;
            `TSP_IDX_MOD10: rbyte = q.mod10;
            `TSP_IDX_STATUS: rbyte = {3'h0, q.slot, q.state, q.busy};
            default: rbyte = 8'h00;
        endcase
        d.pready = access;
        d.pslverr = access & (sel == 8'hFF);
        d.prdata = (access & ~pwrite) ? {24'h000000, rbyte} : 32'h00000000;

        if (wr_en) begin
            case (sel)
                `TSP_IDX_FREQ: d.freq = wbyte;
                `TSP_IDX_P0_HI: d.p0_hi = wbyte;
                `TSP_IDX_P0_LO: d.p0_lo = wbyte;
                `TSP_IDX_P1_HI: d.p1_hi = wbyte;
                `TSP_IDX_P1_LO: d.p1_lo = wbyte;
                `TSP_IDX_P2: d.p2 = wbyte;
                `TSP_IDX_P3: d.p3 = wbyte;
                `TSP_IDX_LEN10: d.len10 = wbyte;
                `TSP_IDX_LEN32: d.len32 = wbyte & `TSP_LEN32_MASK;
                `TSP_IDX_BURST: d.burst = wbyte & `TSP_BURST_MASK;
                `TSP_IDX_MOD10: d.mod10 = wbyte & `TSP_MOD10_MASK;
                default: d.freq = q.freq;
            endcase
        end

        // Symbol sequencer, one bit per clock
        d.tx_valid = 1'b0;
        d.tx_bit = 1'b0;
        pat_word = slot_pattern(q.slot);
        case (q.state)
            tsp_pkg::st_idle: begin
                if (sym_start) begin
                    d.slot = sym_sel;
                    if ((burst_en(sym_sel) | burst_alone(sym_sel))
                        && low_pair_burst_length != 8'h00) begin
                        d.state = tsp_pkg::st_burst;
                        d.cnt = low_pair_burst_length - 8'h01;
                    end else if (!burst_alone(sym_sel)) begin
                        d.state = tsp_pkg::st_pat;
                        d.cnt = {4'h0, slot_length(sym_sel)};
                    end
                end
            end
            tsp_pkg::st_burst: begin
                d.tx_valid = 1'b1;
                d.tx_bit = burst_level(q.slot) ^ slot_invert(q.slot);
                if (q.cnt != 8'h00) begin
                    d.cnt = q.cnt - 8'h01;
                end else if (burst_alone(q.slot)) begin
                    d.state = tsp_pkg::st_idle;
                end else begin
                    d.state = tsp_pkg::st_pat;
                    d.cnt = {4'h0, slot_length(q.slot)};
                end
            end
            tsp_pkg::st_pat: begin
                d.tx_valid = 1'b1;
                d.tx_bit = pat_word[q.cnt[3:0]] ^ slot_invert(q.slot);
                if (q.cnt != 8'h00) begin
                    d.cnt = q.cnt - 8'h01;
                end else begin
                    d.state = tsp_pkg::st_idle;
                end
            end
            default: d.state = tsp_pkg::st_idle;
        endcase
        d.busy = (d.state != tsp_pkg::st_idle);

        // Pair rate settings follow the selected slot
        if (d.slot[1]) begin
            d.bitrate = q.freq[`TSP_HI_BR_MSB:`TSP_HI_BR_LSB];
            d.subcarrier = q.freq[`TSP_HI_SC_BIT];
        end else begin
            d.bitrate = q.freq[`TSP_LO_BR_MSB:`TSP_LO_BR_LSB];
            d.subcarrier = q.freq[`TSP_LO_SC_BIT];
        end
        d.bitrate_rsv = (d.bitrate < `TSP_BR_FIRST);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.freq <= `TSP_RESET_BYTE;
            q.state <= tsp_pkg::st_idle;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign tx_bit = q.tx_bit;
    assign tx_valid = q.tx_valid;
    assign tx_busy = q.busy;
    assign active_bitrate_sel = q.bitrate;
    assign active_subcarrier_sel = q.subcarrier;
    assign active_bitrate_reserved = q.bitrate_rsv;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    a_len_reserved: assert property (
        @(posedge pclk) disable iff (!presetn)
        (q.len32[7] == 1'b0) && (q.len32[3] == 1'b0))
        else $error("reserved length bit set");

    a_burst_reserved: assert property (
        @(posedge pclk) disable iff (!presetn)
        (q.burst[7] == 1'b0) && (q.burst[3] == 1'b0))
        else $error("reserved burst bit set");

    // Slot zero pattern as one word; a concatenation cannot be indexed
    logic [15:0] p0_word;
    assign p0_word = {q.p0_hi, q.p0_lo};

    a_slot0_first_bit: assert property (
        @(posedge pclk) disable iff (!presetn)
        (q.state == tsp_pkg::st_idle && sym_start && sym_sel == 2'h0
         && q.burst[`TSP_B0_EN] == 1'b0 && q.burst[`TSP_B0_ALONE] == 1'b0
         && !wr_en)
        |=> ##1 tx_valid && tx_bit == $past(p0_word[q.len10[`TSP_LEN0_MSB:`TSP_LEN0_LSB]]
            ^ q.mod10[`TSP_INV_BIT], 2))
        else $error("slot zero first bit wrong");

    a_pattern_end: assert property (
        @(posedge pclk) disable iff (!presetn)
        (q.state == tsp_pkg::st_pat && q.cnt == 8'h00)
        |=> tx_valid ##1 !tx_valid)
        else $error("pattern did not end after last bit");

    a_burst_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        (q.state == tsp_pkg::st_burst && !wr_en)
        |=> tx_valid && tx_bit == $past((q.slot[0] ? q.burst[`TSP_B1_LEVEL]
            : q.burst[`TSP_B0_LEVEL]) ^ q.mod10[`TSP_INV_BIT]))
        else $error("burst level wrong");

    a_burst_alone_end: assert property (
        @(posedge pclk) disable iff (!presetn)
        (q.state == tsp_pkg::st_burst && q.cnt == 8'h00
         && (q.slot[0] ? q.burst[`TSP_B1_ALONE] : q.burst[`TSP_B0_ALONE]) && !wr_en)
        |=> q.state == tsp_pkg::st_idle ##1 !tx_valid)
        else $error("pattern sent after burst alone");

    a_burst_start: assert property (
        @(posedge pclk) disable iff (!presetn)
        (q.state == tsp_pkg::st_idle && sym_start && !sym_sel[1]
         && (sym_sel[0] ? q.burst[`TSP_B1_EN] : q.burst[`TSP_B0_EN])
         && low_pair_burst_length != 8'h00)
        |=> q.state == tsp_pkg::st_burst
            && q.cnt == $past(low_pair_burst_length - 8'h01))
        else $error("burst not started");

    a_rate_reserved: assert property (
        @(posedge pclk) disable iff (!presetn)
        $past(presetn) |-> active_bitrate_reserved
            == (active_bitrate_sel == 3'h0 || active_bitrate_sel == 3'h1))
        else $error("reserved bit rate flag wrong");

    // Rate outputs lag the pair register by one clock
    a_rate_follow: assert property (
        @(posedge pclk) disable iff (!presetn)
        $past(presetn) |-> active_bitrate_sel == (q.slot[1]
            ? $past(q.freq[`TSP_HI_BR_MSB:`TSP_HI_BR_LSB])
            : $past(q.freq[`TSP_LO_BR_MSB:`TSP_LO_BR_LSB])))
        else $error("bit rate select wrong");

    a_subcarrier_follow: assert property (
        @(posedge pclk) disable iff (!presetn)
        $past(presetn) |-> active_subcarrier_sel == (q.slot[1]
            ? $past(q.freq[`TSP_HI_SC_BIT]) : $past(q.freq[`TSP_LO_SC_BIT])))
        else $error("subcarrier select wrong");

    a_high_pair_bit: assert property (
        @(posedge pclk) disable iff (!presetn)
        (q.state == tsp_pkg::st_pat && q.slot[1])
        |=> tx_valid && tx_bit == $past(q.slot[0] ? q.p3[q.cnt[2:0]] : q.p2[q.cnt[2:0]]))
        else $error("high pair bit wrong");

    a_slot1_length: assert property (
        @(posedge pclk) disable iff (!presetn)
        (q.state == tsp_pkg::st_idle && sym_start && sym_sel == 2'h1
         && q.burst[`TSP_B1_EN] == 1'b0 && q.burst[`TSP_B1_ALONE] == 1'b0)
        |=> q.state == tsp_pkg::st_pat
            && q.cnt == {4'h0, $past(q.len10[`TSP_LEN1_MSB:`TSP_LEN1_LSB])})
        else $error("slot one length wrong");

    // High pair never bursts, so it goes straight to its pattern
    a_high_pair_length: assert property (
        @(posedge pclk) disable iff (!presetn)
        (q.state == tsp_pkg::st_idle && sym_start && sym_sel[1])
        |=> q.state == tsp_pkg::st_pat
            && q.cnt == {5'h00, $past(sym_sel[0] ? q.len32[`TSP_LEN3_MSB:`TSP_LEN3_LSB]
                : q.len32[`TSP_LEN2_MSB:`TSP_LEN2_LSB])})
        else $error("high pair length wrong");

    a_alone_empty: assert property (
        @(posedge pclk) disable iff (!presetn)
        (q.state == tsp_pkg::st_idle && sym_start && sym_sel == 2'h0
         && q.burst[`TSP_B0_ALONE] && low_pair_burst_length == 8'h00)
        |=> q.state == tsp_pkg::st_idle ##1 !tx_valid)
        else $error("burst alone with no length sent bits");

    a_apb_wait: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("apb ready not one cycle");

endmodule : tsp_gen

`default_nettype wire

// File: core/tsp_params.svh
`ifndef TSP_PARAMS_SVH
`define TSP_PARAMS_SVH

// Register indices; byte address is four times the index
`define TSP_IDX_FREQ 8'h4C
`define TSP_IDX_P0_HI 8'h4D
`define TSP_IDX_P0_LO 8'h4E
`define TSP_IDX_P1_HI 8'h4F
`define TSP_IDX_P1_LO 8'h50
`define TSP_IDX_P2 8'h51
`define TSP_IDX_P3 8'h52
`define TSP_IDX_LEN10 8'h53
`define TSP_IDX_LEN32 8'h54
`define TSP_IDX_BURST 8'h55
`define TSP_IDX_MOD10 8'h56
`define TSP_IDX_STATUS 8'h58

// Frequency fields
`define TSP_HI_SC_BIT 7
`define TSP_HI_BR_MSB 6
`define TSP_HI_BR_LSB 4
`define TSP_LO_SC_BIT 3
`define TSP_LO_BR_MSB 2
`define TSP_LO_BR_LSB 0
`define TSP_BR_FIRST 3'h2

// Length fields
`define TSP_LEN1_MSB 7
`define TSP_LEN1_LSB 4
`define TSP_LEN0_MSB 3
`define TSP_LEN0_LSB 0
`define TSP_LEN3_MSB 6
`define TSP_LEN3_LSB 4
`define TSP_LEN2_MSB 2
`define TSP_LEN2_LSB 0
`define TSP_LEN32_MASK 8'h77

// Burst control fields
`define TSP_B1_LEVEL 6
`define TSP_B1_ALONE 5
`define TSP_B1_EN 4
`define TSP_B0_LEVEL 2
`define TSP_B0_ALONE 1
`define TSP_B0_EN 0
`define TSP_BURST_MASK 8'h77

// Low pair modulation: only the inversion bit is kept
`define TSP_INV_BIT 3
`define TSP_MOD10_MASK 8'h08

`define TSP_RESET_BYTE 8'h00

`endif

// File: core/tsp_pkg.sv
`default_nettype none

package tsp_pkg;
    typedef enum logic [1:0] {st_idle, st_burst, st_pat} tsp_state_e;

    typedef struct packed {
        logic [7:0] freq;
        logic [7:0] p0_hi;
        logic [7:0] p0_lo;
        logic [7:0] p1_hi;
        logic [7:0] p1_lo;
        logic [7:0] p2;
        logic [7:0] p3;
        logic [7:0] len10;
        logic [7:0] len32;
        logic [7:0] burst;
        logic [7:0] mod10;
        tsp_state_e state;
        logic [1:0] slot;
        logic [7:0] cnt;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic tx_bit;
        logic tx_valid;
        logic busy;
        logic [2:0] bitrate;
        logic subcarrier;
        logic bitrate_rsv;
    } tsp_regs_s;
endpackage : tsp_pkg

`default_nettype wire

// File: testbench/tsp_testbench.sv
`include "tsp_params.svh"
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic pclk, presetn, psel, penable, pwrite, sym_start;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic pready, pslverr, tx_bit, tx_valid, tx_busy;
    logic active_subcarrier_sel, active_bitrate_reserved;
    logic [1:0] sym_sel;
    logic [7:0] low_pair_burst_length;
    logic [2:0] active_bitrate_sel;
    integer seed = 32'h1850;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    // Model copy of the registers, index 0 is the frequency register
    logic [7:0] mdl [11];

    tsp_gen dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sym_start(sym_start), .sym_sel(sym_sel),
        .low_pair_burst_length(low_pair_burst_length), .tx_bit(tx_bit),
        .tx_valid(tx_valid), .tx_busy(tx_busy), .active_bitrate_sel(active_bitrate_sel),
        .active_subcarrier_sel(active_subcarrier_sel),
        .active_bitrate_reserved(active_bitrate_reserved)
    );

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    // Run is about 4000 cycles; five times that means a hang
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            close_out();
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function logic [7:0] msk(input int i);
        return (i == 8) ? `TSP_LEN32_MASK : (i == 9) ? `TSP_BURST_MASK :
            (i == 10) ? `TSP_MOD10_MASK : 8'hFF;
    endfunction : msk

    ////////////////////////////////////////////////////////////////////////////////
    // Idle cycle after each transfer keeps psel from being driven twice in a step
    task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
             input logic [3:0] st, output logic [31:0] rd, output logic er);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'hC3C3C3, wd};
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait that never gets an answer
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task check_regs;
        logic [31:0] rd;
        logic er;
        for (int i = 0; i < 11; i++) begin
            apb(1'b0, `TSP_IDX_FREQ + 8'(i), 8'h00, 4'hF, rd, er);
            chk(rd, {24'h0, mdl[i]});
            chk(er, 32'h0);
        end
    endtask : check_regs

    ////////////////////////////////////////////////////////////////////////////////
    task run_sym(input logic [1:0] s, input logic [7:0] bl);
        logic q [$];
        logic [15:0] pat;
        logic inv, en, al, lv, sc;
        logic [2:0] code;
        int n, first, last, cnt, k;
        q = {};
        case (s)
            2'h0: begin
                pat = {mdl[1], mdl[2]};
                n = mdl[7][3:0] + 1;
                {lv, al, en} = mdl[9][2:0];
            end
            2'h1: begin
                pat = {mdl[3], mdl[4]};
                n = mdl[7][7:4] + 1;
                {lv, al, en} = mdl[9][6:4];
            end
            2'h2: begin
                pat = {8'h00, mdl[5]};
                n = mdl[8][2:0] + 1;
                {lv, al, en} = 3'h0;
            end
            default: begin
                pat = {8'h00, mdl[6]};
                n = mdl[8][6:4] + 1;
                {lv, al, en} = 3'h0;
            end
        endcase
        inv = (s < 2'h2) ? mdl[10][`TSP_INV_BIT] : 1'b0;
        if ((en || al) && bl != 8'h00)
            repeat (bl) q.push_back(lv ^ inv);
        if (!al)
            for (k = n - 1; k >= 0; k--) q.push_back(pat[k] ^ inv);
        sym_sel <= s;
        sym_start <= 1'b1;
        low_pair_burst_length <= bl;
        first = -1;
        last = -1;
        cnt = 0;
        for (k = 0; k < 40; k++) begin
            @(negedge pclk);
            if (tx_valid === 1'b1) begin
                if (first < 0)
                    first = k;
                last = k;
                if (cnt < q.size())
                    chk(tx_bit, q[cnt]);
                cnt++;
            end
            chk(tx_busy, k >= 1 && k <= q.size());
            @(posedge pclk);
            // A start held while busy names another slot and must be ignored
            if (k == 0 && q.size() > 0)
                sym_sel <= s + 2'h1;
            if ((k == 0 && q.size() == 0) || k == 1)
                sym_start <= 1'b0;
        end
        chk(cnt, q.size());
        chk(first, (q.size() > 0) ? 2 : -1);
        chk(last - first + 1, (q.size() > 0) ? q.size() : 1);
        code = (s < 2'h2) ? mdl[0][2:0] : mdl[0][6:4];
        sc = (s < 2'h2) ? mdl[0][`TSP_LO_SC_BIT] : mdl[0][`TSP_HI_SC_BIT];
        chk(active_bitrate_sel, code);
        chk(active_subcarrier_sel, sc);
        chk(active_bitrate_reserved, code < `TSP_BR_FIRST);
        chk(tx_busy, 32'h0);
    endtask : run_sym

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] rd;
        logic er;
        logic [7:0] d;
        logic [3:0] st;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        sym_start = 1'b0;
        sym_sel = 2'h0;
        low_pair_burst_length = 8'h00;
        for (int i = 0; i < 11; i++) mdl[i] = `TSP_RESET_BYTE;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check_regs();
        apb(1'b0, 8'h40, 8'h00, 4'hF, rd, er);
        chk(er, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, 8'h5A, 8'hFF, 4'hF, rd, er);
        chk(er, 32'h1);
        for (int it = 0; it < 16; it++) begin
            for (int i = 0; i < 11; i++) begin
                d = 8'($random(seed));
                // Walk every bit-rate code through both pairs
                if (i == 0)
                    d = {d[7], 3'(it), d[3], 3'(it + 3)};
                // Lane 0 strobe off: the write must be dropped
                st = (i == it % 11) ? 4'hE : 4'hF;
                apb(1'b1, `TSP_IDX_FREQ + 8'(i), d, st, rd, er);
                if (st[0])
                    mdl[i] = d & msk(i);
            end
            check_regs();
            for (int s = 0; s < 4; s++) run_sym(2'(s), 8'({$random(seed)} % 6));
        end
        close_out();
    end
endmodule : testbench

`default_nettype wire
